/* src/pif_pkg.sv */
// Shared constants for the peripheral interrupt flag block
package pif_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int AW = 5;
    localparam int DW = 8;
    localparam logic [AW-1:0] IDX_CORE_TSC = 5'h08;
    localparam logic [AW-1:0] IDX_SER_CTL = 5'h0A;
    localparam logic [AW-1:0] IDX_SER_STS = 5'h0B;
    localparam logic [AW-1:0] IDX_SER_DATA = 5'h0C;
    localparam logic [AW-1:0] IDX_PT_CTL = 5'h12;
    localparam logic [AW-1:0] IDX_PT_STS = 5'h13;
    localparam logic [AW-1:0] IDX_CAP_LOW = 5'h15;
    localparam logic [AW-1:0] IDX_CMP_LOW = 5'h17;
    localparam logic [AW-1:0] IDX_CNT_LOW = 5'h19;
    localparam logic [AW-1:0] IDX_ANA_CTL = 5'h1D;
    localparam logic [AW-1:0] IDX_ANA_STS = 5'h1E;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // core_timer_status_control
    localparam int CT_OVF_FLAG = 7;
    localparam int CT_PER_FLAG = 6;
    localparam int CT_OVF_EN = 5;
    localparam int CT_PER_EN = 4;
    localparam int CT_OVF_RST = 3;
    localparam int CT_PER_RST = 2;
    localparam logic [DW-1:0] CT_RW_MASK = 8'h33;
    // prog_timer_control / prog_timer_status
    localparam int PT_CAP_EN = 7;
    localparam int PT_CMP_EN = 6;
    localparam int PT_OVF_EN = 5;
    localparam int PT_EDGE = 1;
    localparam int PT_CAP_FLAG = 7;
    localparam int PT_CMP_FLAG = 6;
    localparam int PT_OVF_FLAG = 5;
    // serial_control / serial_status
    localparam int SC_DONE_EN = 7;
    localparam int SC_DONE_RST = 5;
    localparam logic [DW-1:0] SC_RW_MASK = 8'hDF;
    localparam int SS_DONE_FLAG = 7;
    // analog_control / analog_status
    localparam int AC_CMP_EN = 7;
    localparam int AC_TRIG_CAP = 6;
    localparam int AS_TWO_FLAG = 7;
    localparam int AS_ONE_FLAG = 6;
    localparam int AS_TWO_RST = 5;
    localparam int AS_ONE_RST = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DW-1:0] CT_RST_VAL = 8'h03;
    localparam logic [DW-1:0] PT_CTL_RST_VAL = 8'h00;
    localparam logic [DW-1:0] SC_RST_VAL = 8'h00;
    localparam logic [DW-1:0] SD_RST_VAL = 8'h00;
    localparam logic [DW-1:0] AC_RST_VAL = 8'h00;

    // ------------------------------------------------------------------
    // Flag slots
    // ------------------------------------------------------------------
    localparam int NUM_FLAGS = 8;
    localparam int F_CORE_OVF = 0;
    localparam int F_PERIODIC = 1;
    localparam int F_CAPTURE = 2;
    localparam int F_COMPARE = 3;
    localparam int F_PT_OVF = 4;
    localparam int F_SERIAL = 5;
    localparam int F_CMP_ONE = 6;
    localparam int F_CMP_TWO = 7;

    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } pif_bus_e;

endpackage

/* src/pif_bus.sv */
// Avalon-MM waitrequest handshake with one wait state
`timescale 1ns/1ps
`default_nettype none
module pif_bus
    import pif_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic bus_read,
    input wire logic bus_write,
    output logic waitrequest,
    output logic sample,
    output logic done
);

    pif_bus_e state_r;
    pif_bus_e state_nxt;
    logic req;

    assign req = bus_read | bus_write;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            BUS_IDLE:
            begin
                if (req)
                    state_nxt = BUS_ACK;
            end
            BUS_ACK: state_nxt = BUS_IDLE;
            default: state_nxt = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            state_r <= BUS_IDLE;
        else
            state_r <= state_nxt;
    end

    // High while idle, so a new request always meets a wait state
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            waitrequest <= 1'b1;
        else
            waitrequest <= (state_nxt != BUS_ACK);
    end

    assign sample = req & (state_r == BUS_IDLE);
    assign done = req & (state_r == BUS_ACK);

endmodule // pif_bus
`default_nettype wire

/* src/pif_flag.sv */
// One sticky interrupt flag with direct and two-step clearing
`timescale 1ns/1ps
`default_nettype none
module pif_flag
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic set_ev,
    input wire logic observe,
    input wire logic access,
    input wire logic direct_clr,
    output logic flag_r
);

    logic armed_r;
    logic clr;

    assign clr = direct_clr | (armed_r & access);

    // Set beats any clear in the same cycle
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            flag_r <= 1'b0;
        else
            flag_r <= set_ev | (flag_r & ~clr);
    end

    // Arms only on a status read that saw the flag set
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            armed_r <= 1'b0;
        else if (observe)
            armed_r <= 1'b1;
        else if (clr)
            armed_r <= 1'b0;
    end

endmodule // pif_flag
`default_nettype wire

/* src/pif_top.sv */
// Peripheral interrupt flags, enables and request to the processor core
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pif_top
    import pif_pkg::*;
#(
    parameter int NUM_SRC = NUM_FLAGS
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic power_on_rst,
    input wire logic [AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_irq_mask,
    input wire logic core_overflow_event,
    input wire logic periodic_event,
    input wire logic capture_event,
    input wire logic compare_event,
    input wire logic counter_overflow_event,
    input wire logic serial_done_event,
    input wire logic comparator_one_event,
    input wire logic comparator_two_event,
    input wire logic [DW-1:0] capture_value_low,
    input wire logic [DW-1:0] compare_value_low,
    input wire logic [DW-1:0] counter_low_byte,
    output logic irq_request,
    output logic [NUM_SRC-1:0] source_request,
    output logic capture_trigger,
    output logic [DW-1:0] core_timer_control,
    output logic [DW-1:0] prog_timer_control,
    output logic [DW-1:0] serial_control,
    output logic [DW-1:0] serial_shift_data,
    output logic [DW-1:0] analog_control
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    generate
        if (NUM_SRC != NUM_FLAGS)
        begin : g_bad_src
            $error("NUM_SRC must equal the number of flag slots");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [AW-1:0] addr, input logic [AW-1:0] idx);
        hit = (addr == idx);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic bus_sample;
    logic bus_done;
    logic wr_done;
    logic rd_done;
    logic acc_done;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;
    logic [DW-1:0] core_ctl_r;
    logic [DW-1:0] pt_ctl_r;
    logic [DW-1:0] ser_ctl_r;
    logic [DW-1:0] ser_data_r;
    logic [DW-1:0] ana_ctl_r;
    logic [NUM_SRC-1:0] set_v;
    logic [NUM_SRC-1:0] obs_v;
    logic [NUM_SRC-1:0] acc_v;
    logic [NUM_SRC-1:0] clr_v;
    logic [NUM_SRC-1:0] flag_v;
    logic [NUM_SRC-1:0] en_v;
    logic [NUM_SRC-1:0] gated;
    logic cmp_two_trig;
    logic irq_request_r;
    logic [NUM_SRC-1:0] source_request_r;
    logic capture_trigger_r;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    pif_bus u_bus (
        .clock(clock),
        .sys_rst(sys_rst),
        .bus_read(avs_read),
        .bus_write(avs_write),
        .waitrequest(avs_waitrequest),
        .sample(bus_sample),
        .done(bus_done)
    );

    // Side effects land on the edge that ends the transfer, one cycle after the wait state
    assign wdata = avs_writedata[DW-1:0];
    assign wr_done = bus_done & avs_write & avs_byteenable[0];
    assign rd_done = bus_done & avs_read;
    assign acc_done = bus_done & (avs_read | avs_write);

    always_comb
    begin
        rdata_nxt = 8'h00;
        case (avs_address)
            IDX_CORE_TSC:
            begin
                rdata_nxt = core_ctl_r & CT_RW_MASK;
                rdata_nxt[CT_OVF_FLAG] = flag_v[F_CORE_OVF];
                rdata_nxt[CT_PER_FLAG] = flag_v[F_PERIODIC];
            end
            IDX_SER_CTL: rdata_nxt = ser_ctl_r & SC_RW_MASK;
            IDX_SER_STS: rdata_nxt[SS_DONE_FLAG] = flag_v[F_SERIAL];
            IDX_SER_DATA: rdata_nxt = ser_data_r;
            IDX_PT_CTL: rdata_nxt = pt_ctl_r;
            IDX_PT_STS:
            begin
                rdata_nxt[PT_CAP_FLAG] = flag_v[F_CAPTURE];
                rdata_nxt[PT_CMP_FLAG] = flag_v[F_COMPARE];
                rdata_nxt[PT_OVF_FLAG] = flag_v[F_PT_OVF];
            end
            IDX_CAP_LOW: rdata_nxt = capture_value_low;
            IDX_CMP_LOW: rdata_nxt = compare_value_low;
            IDX_CNT_LOW: rdata_nxt = counter_low_byte;
            IDX_ANA_CTL: rdata_nxt = ana_ctl_r;
            IDX_ANA_STS:
            begin
                rdata_nxt[AS_TWO_FLAG] = flag_v[F_CMP_TWO];
                rdata_nxt[AS_ONE_FLAG] = flag_v[F_CMP_ONE];
            end
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data is frozen while the master waits, so status seen equals data taken
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_r <= 8'h00;
        else if (bus_sample & avs_read)
            rdata_r <= rdata_nxt;
    end

    assign avs_readdata = {24'h000000, rdata_r};

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            core_ctl_r <= CT_RST_VAL;
        else if (wr_done & hit(avs_address, IDX_CORE_TSC))
            core_ctl_r <= wdata & CT_RW_MASK;
    end

    // Only power-on clears the timer enables and edge select
    always_ff @(posedge clock or posedge power_on_rst)
    begin
        if (power_on_rst)
            pt_ctl_r <= PT_CTL_RST_VAL;
        else if (wr_done & hit(avs_address, IDX_PT_CTL))
            pt_ctl_r <= wdata;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            ser_ctl_r <= SC_RST_VAL;
        else if (wr_done & hit(avs_address, IDX_SER_CTL))
            ser_ctl_r <= wdata & SC_RW_MASK;
    end

    // Data register survives a chip reset
    always_ff @(posedge clock or posedge power_on_rst)
    begin
        if (power_on_rst)
            ser_data_r <= SD_RST_VAL;
        else if (wr_done & hit(avs_address, IDX_SER_DATA))
            ser_data_r <= wdata;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            ana_ctl_r <= AC_RST_VAL;
        else if (wr_done & hit(avs_address, IDX_ANA_CTL))
            ana_ctl_r <= wdata;
    end

    // ------------------------------------------------------------------
    // Flag set, observe, access and direct clear terms
    // ------------------------------------------------------------------
    assign cmp_two_trig = comparator_two_event & ana_ctl_r[AC_TRIG_CAP];

    always_comb
    begin
        set_v = '0;
        set_v[F_CORE_OVF] = core_overflow_event;
        set_v[F_PERIODIC] = periodic_event;
        set_v[F_CAPTURE] = capture_event | cmp_two_trig;
        set_v[F_COMPARE] = compare_event;
        set_v[F_PT_OVF] = counter_overflow_event;
        set_v[F_SERIAL] = serial_done_event;
        set_v[F_CMP_ONE] = comparator_one_event;
        set_v[F_CMP_TWO] = comparator_two_event;
    end

    always_comb
    begin
        obs_v = '0;
        obs_v[F_CAPTURE] = rd_done & hit(avs_address, IDX_PT_STS) & rdata_r[PT_CAP_FLAG];
        obs_v[F_COMPARE] = rd_done & hit(avs_address, IDX_PT_STS) & rdata_r[PT_CMP_FLAG];
        obs_v[F_PT_OVF] = rd_done & hit(avs_address, IDX_PT_STS) & rdata_r[PT_OVF_FLAG];
        obs_v[F_SERIAL] = rd_done & hit(avs_address, IDX_SER_STS) & rdata_r[SS_DONE_FLAG];
    end

    always_comb
    begin
        acc_v = '0;
        acc_v[F_CAPTURE] = rd_done & hit(avs_address, IDX_CAP_LOW);
        acc_v[F_COMPARE] = acc_done & hit(avs_address, IDX_CMP_LOW);
        acc_v[F_PT_OVF] = acc_done & hit(avs_address, IDX_CNT_LOW);
        acc_v[F_SERIAL] = acc_done & hit(avs_address, IDX_SER_DATA);
    end

    always_comb
    begin
        clr_v = '0;
        clr_v[F_CORE_OVF] = wr_done & hit(avs_address, IDX_CORE_TSC)
            & wdata[CT_OVF_RST];
        clr_v[F_PERIODIC] = wr_done & hit(avs_address, IDX_CORE_TSC)
            & wdata[CT_PER_RST];
        clr_v[F_SERIAL] = wr_done & hit(avs_address, IDX_SER_CTL)
            & wdata[SC_DONE_RST];
        clr_v[F_CMP_ONE] = wr_done & hit(avs_address, IDX_ANA_STS)
            & wdata[AS_ONE_RST];
        clr_v[F_CMP_TWO] = wr_done & hit(avs_address, IDX_ANA_STS)
            & wdata[AS_TWO_RST];
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // Timer flags also reset here: a chip reset clears them all
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_flag
            pif_flag u_flag (
                .clock(clock),
                .sys_rst(sys_rst),
                .set_ev(set_v[gi]),
                .observe(obs_v[gi]),
                .access(acc_v[gi]),
                .direct_clr(clr_v[gi]),
                .flag_r(flag_v[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Enables and gated requests
    // ------------------------------------------------------------------
    always_comb
    begin
        en_v = '0;
        en_v[F_CORE_OVF] = core_ctl_r[CT_OVF_EN];
        en_v[F_PERIODIC] = core_ctl_r[CT_PER_EN];
        en_v[F_CAPTURE] = pt_ctl_r[PT_CAP_EN];
        en_v[F_COMPARE] = pt_ctl_r[PT_CMP_EN];
        en_v[F_PT_OVF] = pt_ctl_r[PT_OVF_EN];
        en_v[F_SERIAL] = ser_ctl_r[SC_DONE_EN];
        en_v[F_CMP_ONE] = ana_ctl_r[AC_CMP_EN];
        en_v[F_CMP_TWO] = ana_ctl_r[AC_CMP_EN];
    end

    assign gated = flag_v & en_v;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            source_request_r <= '0;
        else
            source_request_r <= gated;
    end

    // Level request; the core mask holds it off without touching flags
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            irq_request_r <= 1'b0;
        else
            irq_request_r <= (|gated) & ~cpu_irq_mask;
    end

    // Tells the timer to latch its counter into the capture value
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            capture_trigger_r <= 1'b0;
        else
            capture_trigger_r <= cmp_two_trig;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign irq_request = irq_request_r;
    assign source_request = source_request_r;
    assign capture_trigger = capture_trigger_r;
    assign core_timer_control = core_ctl_r;
    assign prog_timer_control = pt_ctl_r;
    assign serial_control = ser_ctl_r;
    assign serial_shift_data = ser_data_r;
    assign analog_control = ana_ctl_r;

endmodule // pif_top
`default_nettype wire

/* verif/pif_cpu_model.sv */
// Processor core model: global interrupt mask and count of taken requests
`timescale 1ns/1ps
`default_nettype none
module pif_cpu_model
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic irq_request,
    input wire logic mask_set,
    output logic cpu_irq_mask,
    output logic [15:0] taken
);
    // Reset sets the mask so nothing is serviced before software is ready
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            cpu_irq_mask <= 1'b1;
        else
            cpu_irq_mask <= mask_set;
    end
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            taken <= 16'h0000;
        else if (irq_request && !cpu_irq_mask)
            taken <= taken + 16'h0001;
    end
endmodule // pif_cpu_model
`default_nettype wire

/* verif/pif_top_assertions.sv */
// Concurrent checks on the peripheral interrupt flag block ports
`timescale 1ns/1ps
`default_nettype none
module pif_top_assertions
    import pif_pkg::*;
#(
    parameter int NUM_SRC = NUM_FLAGS
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [AW-1:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic cpu_irq_mask,
    input wire logic core_overflow_event,
    input wire logic capture_event,
    input wire logic serial_done_event,
    input wire logic comparator_two_event,
    input wire logic irq_request,
    input wire logic [NUM_SRC-1:0] source_request,
    input wire logic capture_trigger,
    input wire logic [DW-1:0] core_timer_control,
    input wire logic [DW-1:0] prog_timer_control,
    input wire logic [DW-1:0] serial_control,
    input wire logic [DW-1:0] analog_control
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_ser_clr;
        avs_write && !avs_waitrequest && avs_address == IDX_SER_CTL
            && avs_writedata[SC_DONE_RST] && avs_byteenable[0];
    endsequence
    sequence s_quiet;
        !serial_done_event [*2];
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_mask_blocks: assert property (cpu_irq_mask |=> !irq_request)
        else $error("request passed a set mask");
    a_irq_level: assert property (irq_request == ((|source_request) && !$past(cpu_irq_mask)))
        else $error("request level does not follow sources");
    a_core_req: assert property (core_overflow_event && core_timer_control[CT_OVF_EN]
        |-> ##2 source_request[F_CORE_OVF])
        else $error("core overflow request missing");
    a_cap_req: assert property (capture_event && prog_timer_control[PT_CAP_EN]
        |-> ##2 source_request[F_CAPTURE])
        else $error("capture request missing");
    a_ser_req: assert property (serial_done_event && serial_control[SC_DONE_EN]
        |-> ##2 source_request[F_SERIAL])
        else $error("serial request missing");
    a_ser_direct: assert property (s_ser_clr ##0 s_quiet |=> !source_request[F_SERIAL])
        else $error("serial flag not cleared by reset bit");
    a_trig_pulse: assert property (comparator_two_event && analog_control[AC_TRIG_CAP]
        |=> capture_trigger)
        else $error("capture trigger missing");
    a_trig_cause: assert property (capture_trigger |-> $past(comparator_two_event)
        && $past(analog_control[AC_TRIG_CAP]))
        else $error("capture trigger without cause");
    a_cmp_gate: assert property (source_request[F_CMP_TWO] |-> $past(analog_control[AC_CMP_EN]))
        else $error("comparator request without enable");
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait request low too long");
endmodule // pif_top_assertions
bind pif_top pif_top_assertions #(.NUM_SRC(NUM_SRC)) u_pif_top_assertions (.clock, .sys_rst,
    .avs_address, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
    .cpu_irq_mask, .core_overflow_event, .capture_event, .serial_done_event,
    .comparator_two_event, .irq_request, .source_request, .capture_trigger,
    .core_timer_control, .prog_timer_control, .serial_control, .analog_control);
`default_nettype wire

/* verif/pif_tb_top.sv */
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module pif_tb_top
    import pif_pkg::*;
;
    logic clock = 1'b0, sys_rst = 1'b1, power_on_rst = 1'b1, mask_set = 1'b1;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq_request, capture_trigger;
    logic cpu_irq_mask;
    logic [AW-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic [7:0] evt = 8'h00, cap_lo, cmp_lo, cnt_lo, d, e, source_request;
    logic [7:0] ctc, prog_timer_control, sc, sd, ac;
    logic [15:0] taken;
    logic [7:0] exp_q[$];
    int failures = 0, tests_run = 0, cyc = 0;
    pif_top u_pif_top (.clock, .sys_rst, .power_on_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_irq_mask,
        .core_overflow_event(evt[0]), .periodic_event(evt[1]), .capture_event(evt[2]),
        .compare_event(evt[3]), .counter_overflow_event(evt[4]), .serial_done_event(evt[5]),
        .comparator_one_event(evt[6]), .comparator_two_event(evt[7]),
        .capture_value_low(cap_lo), .compare_value_low(cmp_lo), .counter_low_byte(cnt_lo),
        .irq_request, .source_request, .capture_trigger, .core_timer_control(ctc),
        .prog_timer_control, .serial_control(sc), .serial_shift_data(sd), .analog_control(ac));
    pif_cpu_model u_pif_cpu_model (.clock, .sys_rst, .irq_request, .mask_set, .cpu_irq_mask,
        .taken);
    always #20 clock = ~clock;
    // ------------------------------------------------------------
    // Read result scoreboard and hang guard
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        cyc++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
        begin
            e = exp_q.pop_front();
            `CHK(avs_readdata, {24'h0, e})
        end
        if (cyc == 4000)
        begin
            failures++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [7:0] v);
        @(posedge clock);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h0, v};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [AW-1:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic wt;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge clock);
        evt <= m;
        @(posedge clock);
        evt <= 8'h00;
        @(posedge clock);
        #1;
    endtask
    task automatic finish_test;
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cap_lo = $urandom(32'h0E83);
        cmp_lo = $urandom;
        cnt_lo = $urandom;
        d = $urandom;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        power_on_rst <= 1'b0;
        rdc(IDX_CORE_TSC, CT_RST_VAL);
        rdc(IDX_ANA_STS, 8'h00);
        rdc(5'h01, 8'h00);
        rdc(IDX_CMP_LOW, cmp_lo);
        bus(1'b1, IDX_SER_DATA, d);
        rdc(IDX_SER_DATA, d);
        `CHK(sd, d)
        // Core timer sources, masked then unmasked
        bus(1'b1, IDX_CORE_TSC, 8'h33);
        pulse(8'h03);
        `CHK(ctc, 8'h33)
        `CHK(source_request[1:0], 2'b11)
        `CHK(irq_request, 1'b0)
        @(posedge clock);
        mask_set <= 1'b0;
        wt();
        `CHK(irq_request, 1'b1)
        bus(1'b1, IDX_CORE_TSC, 8'h3B);
        rdc(IDX_CORE_TSC, 8'h73);
        bus(1'b1, IDX_CORE_TSC, 8'h37);
        rdc(IDX_CORE_TSC, 8'h33);
        // Programmable timer two-step clears, low byte first must not clear
        bus(1'b1, IDX_PT_CTL, 8'hE2);
        pulse(8'h1C);
        `CHK(source_request[4:2], 3'b111)
        rdc(IDX_CAP_LOW, cap_lo);
        rdc(IDX_PT_STS, 8'hE0);
        rdc(IDX_CAP_LOW, cap_lo);
        rdc(IDX_PT_STS, 8'h60);
        bus(1'b1, IDX_CMP_LOW, 8'h5A);
        rdc(IDX_PT_STS, 8'h20);
        rdc(IDX_CNT_LOW, cnt_lo);
        rdc(IDX_PT_STS, 8'h00);
        // Mid-run chip reset keeps timer enables
        pulse(8'h01);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        `CHK(prog_timer_control, 8'hE2)
        `CHK({ctc, sd}, {CT_RST_VAL, d})
        rdc(IDX_CORE_TSC, CT_RST_VAL);
        // Serial flag by two-step and direct clear
        bus(1'b1, IDX_SER_CTL, 8'h80);
        pulse(8'h20);
        `CHK(source_request[5], 1'b1)
        rdc(IDX_SER_STS, 8'h80);
        bus(1'b1, IDX_SER_DATA, d);
        rdc(IDX_SER_STS, 8'h00);
        pulse(8'h20);
        bus(1'b1, IDX_SER_CTL, 8'hA0);
        rdc(IDX_SER_CTL, 8'h80);
        `CHK(sc, 8'h80)
        rdc(IDX_SER_STS, 8'h00);
        // Comparators and triggered capture, enable set late
        bus(1'b1, IDX_PT_CTL, 8'h02);
        bus(1'b1, IDX_ANA_CTL, 8'hC0);
        pulse(8'hC0);
        `CHK(ac, 8'hC0)
        `CHK(source_request[7:6], 2'b11)
        `CHK(source_request[2], 1'b0)
        rdc(IDX_PT_STS, 8'h80);
        bus(1'b1, IDX_PT_CTL, 8'h82);
        wt();
        `CHK(source_request[2], 1'b1)
        bus(1'b1, IDX_ANA_STS, 8'h10);
        rdc(IDX_ANA_STS, 8'h80);
        bus(1'b1, IDX_ANA_STS, 8'h20);
        rdc(IDX_ANA_STS, 8'h00);
        `CHK(taken != 16'h0000, 1'b1)
        wt();
        finish_test();
    end
endmodule // pif_tb_top
`default_nettype wire
